// ===== hdl/swdtc_top.sv
// supervisory timer with trip counter behind an apb slave
//
// Behaviour
// - a 32-bit counter counts down from the software load value to expiry.
// - a reload write of the key value restores the counter to the load value.
// - expiry without reload raises a system reset.
// - that reset drives both the core and peripheral reset outputs.
// - after hardware reset the timer is disabled and does not count.
// - a control bit shows whether the last reset came from expiry.
// - once expirations exceed the trip limit the reset output stays low until hardware reset.
// - the trip count survives watchdog resets and only hardware reset clears it.
// - a current trip count field counts watchdog resets, saturating at all ones, and is readable.
`timescale 1ns/1ns
`default_nettype none
module swdtc_top
    import swdtc_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int TRIP_W = 8,
    parameter int PULSE_CYCLES = SWDTC_RST_PULSE_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic supervisor_reset_out_n,
    output logic core_reset_n,
    output logic periph_reset_n
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (CNT_W != 32) begin : g_bad_cnt
        $error("counter width must be 32");
    end
    if (TRIP_W < 1 || TRIP_W > 8) begin : g_bad_trip
        $error("trip width must be 1..8");
    end
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
        $error("pulse length must be 1..255");
    end

    logic wr_stb;
    logic rd_stb;
    logic mapped;
    logic [31:0] load_q;
    logic [31:0] count_q;
    logic en_q;
    logic wdrst_q;
    logic [TRIP_W-1:0] trip_lim_q;
    logic [TRIP_W-1:0] trip_cur_q;
    logic [7:0] pulse_q;
    logic rst_out_q;
    swdtc_state_e state_q;
    swdtc_status_s status;
    logic expire;
    logic reload;

    swdtc_apb_if u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .mapped(mapped)
    );

    function automatic logic wr_to(input logic stb, input logic [7:0] a, input logic [7:0] off);
        wr_to = stb && (a == off);
    endfunction

    assign reload = wr_to(wr_stb, paddr, SWDTC_OFF_RELOAD) && (pwdata == SWDTC_RELOAD_KEY);
    assign expire = (state_q == SWDTC_RUN) && en_q && (count_q == '0) && !reload;

    // ****************************************
    // load value and enable
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= SWDTC_LOAD_RESET;
        end else if (wr_to(wr_stb, paddr, SWDTC_OFF_LOAD)) begin
            load_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
        end else if (expire) begin
            en_q <= 1'b0;
        end else if (wr_to(wr_stb, paddr, SWDTC_OFF_CTRL) && state_q != SWDTC_LOCK) begin
            en_q <= pwdata[SWDTC_CTRL_EN_BIT];
        end
    end

    // ****************************************
    // down counter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= SWDTC_LOAD_RESET;
        end else if (state_q == SWDTC_IDLE || reload) begin
            count_q <= load_q;
        end else if (state_q == SWDTC_RUN && count_q != '0) begin
            count_q <= count_q - 32'h0000_0001;
        end
    end

    // ****************************************
    // state machine
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SWDTC_IDLE;
        end else begin
            case (state_q)
                SWDTC_IDLE: begin
                    if (en_q) begin
                        state_q <= SWDTC_RUN;
                    end
                end
                SWDTC_RUN: begin
                    if (!en_q) begin
                        state_q <= SWDTC_IDLE;
                    end else if (expire) begin
                        if (trip_cur_q >= trip_lim_q) begin
                            state_q <= SWDTC_LOCK;
                        end else begin
                            state_q <= SWDTC_PULSE;
                        end
                    end
                end
                SWDTC_PULSE: begin
                    if (pulse_q == 8'h01) begin
                        state_q <= SWDTC_IDLE;
                    end
                end
                SWDTC_LOCK: state_q <= SWDTC_LOCK;
                default: state_q <= SWDTC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 8'h00;
        end else if (expire) begin
            pulse_q <= PULSE_CYCLES[7:0];
        end else if (pulse_q != 8'h00) begin
            pulse_q <= pulse_q - 8'h01;
        end
    end

    // ****************************************
    // trip counter and status
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_lim_q <= SWDTC_TRIP_RESET[TRIP_W-1:0];
        end else if (wr_to(wr_stb, paddr, SWDTC_OFF_TRIP) && state_q != SWDTC_LOCK) begin
            trip_lim_q <= pwdata[TRIP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_cur_q <= SWDTC_TRIP_RESET[TRIP_W-1:0];
        end else if (expire && trip_cur_q != '1) begin
            trip_cur_q <= trip_cur_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdrst_q <= 1'b0;
        end else if (expire) begin
            wdrst_q <= 1'b1;
        end else if (wr_to(wr_stb, paddr, SWDTC_OFF_CTRL) && pwdata[SWDTC_CTRL_WDRST_BIT]) begin
            wdrst_q <= 1'b0;
        end
    end

    // ****************************************
    // reset outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_out_q <= 1'b1;
        end else begin
            rst_out_q <= !(expire || state_q == SWDTC_PULSE || state_q == SWDTC_LOCK);
        end
    end

    assign supervisor_reset_out_n = rst_out_q;
    assign core_reset_n = rst_out_q;
    assign periph_reset_n = rst_out_q;

    // ****************************************
    // read data
    // ****************************************
    assign status = '{en: en_q, wd_reset_flag: wdrst_q, locked: state_q == SWDTC_LOCK};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                SWDTC_OFF_CTRL: begin
                    prdata <= 32'h0000_0000;
                    prdata[SWDTC_CTRL_EN_BIT] <= status.en;
                    prdata[SWDTC_CTRL_WDRST_BIT] <= status.wd_reset_flag;
                    prdata[SWDTC_CTRL_LOCK_BIT] <= status.locked;
                end
                SWDTC_OFF_LOAD: prdata <= load_q;
                SWDTC_OFF_COUNT: prdata <= count_q;
                SWDTC_OFF_TRIP: begin
                    prdata <= 32'h0000_0000;
                    prdata[TRIP_W-1:0] <= trip_lim_q;
                    prdata[SWDTC_TRIP_CUR_LSB +: TRIP_W] <= trip_cur_q;
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    logic unused_rd;
    assign unused_rd = rd_stb & mapped;
endmodule
`default_nettype wire

// ===== shared/swdtc_pkg.sv
// package: register map and constants of the supervisory timer
package swdtc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] SWDTC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SWDTC_OFF_LOAD = 8'h04;
    localparam logic [7:0] SWDTC_OFF_COUNT = 8'h08;
    localparam logic [7:0] SWDTC_OFF_RELOAD = 8'h0c;
    localparam logic [7:0] SWDTC_OFF_TRIP = 8'h10;
    localparam logic [31:0] SWDTC_RELOAD_KEY = 32'h0000_5a5a;
    // ****************************************
    // control fields
    // ****************************************
    localparam int SWDTC_CTRL_EN_BIT = 0;
    localparam int SWDTC_CTRL_WDRST_BIT = 1;
    localparam int SWDTC_CTRL_LOCK_BIT = 2;
    localparam int SWDTC_TRIP_CUR_LSB = 8;
    localparam logic [31:0] SWDTC_LOAD_RESET = 32'hffff_ffff;
    localparam logic [7:0] SWDTC_TRIP_RESET = 8'h00;
    localparam int SWDTC_RST_PULSE_CYCLES = 16;

    typedef struct packed {
        logic en;
        logic wd_reset_flag;
        logic locked;
    } swdtc_status_s;

    typedef enum logic [1:0] {
        SWDTC_IDLE,
        SWDTC_RUN,
        SWDTC_PULSE,
        SWDTC_LOCK
    } swdtc_state_e;
endpackage

// ===== hdl/swdtc_apb_if.sv
// apb slave decode: one-cycle access with error on unmapped offsets
`timescale 1ns/1ns
`default_nettype none
module swdtc_apb_if
    import swdtc_pkg::*;
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    output logic pready,
    output logic pslverr,
    output logic wr_stb,
    output logic rd_stb,
    output logic mapped
);
    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        case (paddr)
            SWDTC_OFF_CTRL, SWDTC_OFF_LOAD, SWDTC_OFF_COUNT,
            SWDTC_OFF_RELOAD, SWDTC_OFF_TRIP: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wr_stb = psel & penable & pwrite & mapped;
    assign rd_stb = psel & penable & ~pwrite & mapped;
endmodule
`default_nettype wire

// ===== verif/swdtc_chk.sv
// checker: port assertions for the supervisory timer
`timescale 1ns/1ns
`default_nettype none
module swdtc_chk
    import swdtc_pkg::*;
#(
    parameter int PULSE_CYCLES = SWDTC_RST_PULSE_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supervisor_reset_out_n,
    input wire logic core_reset_n,
    input wire logic periph_reset_n
);
    logic [7:0] low_q;
    logic en_seen_q;
    logic umap;
    assign umap = !(paddr inside {SWDTC_OFF_CTRL, SWDTC_OFF_LOAD, SWDTC_OFF_COUNT,
        SWDTC_OFF_RELOAD, SWDTC_OFF_TRIP});
    // cycles the reset output has been low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 8'h00;
        end else if (supervisor_reset_out_n) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hff) begin
            low_q <= low_q + 8'h01;
        end
    end
    // any enable write since hardware reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_seen_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == SWDTC_OFF_CTRL
            && pwdata[SWDTC_CTRL_EN_BIT]) begin
            en_seen_q <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // assertions
    // ****************************************
    AST_CORE_EQ: assert property (core_reset_n == supervisor_reset_out_n)
        else $error("core reset differs");
    AST_PERIPH_EQ: assert property (periph_reset_n == supervisor_reset_out_n)
        else $error("peripheral reset differs");
    AST_IDLE: assert property (!en_seen_q |-> supervisor_reset_out_n)
        else $error("reset while never enabled");
    AST_PULSE: assert property ($rose(supervisor_reset_out_n) |-> low_q == PULSE_CYCLES + 1)
        else $error("bad reset pulse length");
    AST_LOCK: assert property (low_q > PULSE_CYCLES + 1 |-> !supervisor_reset_out_n)
        else $error("locked reset released");
    AST_READY: assert property (pready == (psel && penable))
        else $error("pready wrong");
    AST_SLVERR: assert property (psel && penable |-> pslverr == umap)
        else $error("pslverr wrong");
    AST_RD0: assert property (psel && !penable && !pwrite && umap |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    CV_EXP: cover property ($fell(supervisor_reset_out_n));
    CV_LOCK: cover property (low_q == 8'h0a);
    CV_ERR: cover property (pslverr);
endmodule
bind swdtc_top swdtc_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supervisor_reset_out_n(supervisor_reset_out_n), .core_reset_n(core_reset_n),
    .periph_reset_n(periph_reset_n));
`default_nettype wire

// ===== verif/swdtc_top_tb.sv
// testbench: apb scenarios for the supervisory timer
`timescale 1ns/1ns
`default_nettype none
module swdtc_top_tb import swdtc_pkg::*;;
    localparam int PULSE = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, rst_n, core_n, per_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, c1;
    int mismatches, n_checks, i;
    swdtc_top #(.CNT_W(32), .TRIP_W(8), .PULSE_CYCLES(PULSE)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supervisor_reset_out_n(rst_n), .core_reset_n(core_n), .periph_reset_n(per_n));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_low;
        i = 0;
        while (rst_n !== 1'b0 && i < 500) begin
            i++;
            @(posedge pclk);
            #1;
        end
        chk({31'h0, rst_n}, 32'h0);
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({29'h0, rst_n, core_n, per_n}, 32'h7);
        xfer(1'b0, SWDTC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, SWDTC_OFF_LOAD, 32'h0);
        chk(rd, SWDTC_LOAD_RESET);
        repeat (40) @(posedge pclk);
        #1;
        chk({31'h0, rst_n}, 32'h1);
        xfer(1'b0, 8'h14, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        xfer(1'b1, SWDTC_OFF_TRIP, 32'h1);
        xfer(1'b1, SWDTC_OFF_LOAD, 32'd40);
        xfer(1'b1, SWDTC_OFF_CTRL, 32'h1);
        xfer(1'b0, SWDTC_OFF_COUNT, 32'h0);
        c1 = rd;
        xfer(1'b0, SWDTC_OFF_COUNT, 32'h0);
        chk(c1 - rd, 32'h3);
        repeat (20) xfer(1'b1, SWDTC_OFF_RELOAD, SWDTC_RELOAD_KEY);
        #1;
        chk({31'h0, rst_n}, 32'h1);
        wait_low();
        i = 0;
        while (rst_n === 1'b0 && i < 20) begin
            i++;
            @(posedge pclk);
            #1;
        end
        chk(32'(i), 32'(PULSE + 1));
        xfer(1'b0, SWDTC_OFF_CTRL, 32'h0);
        chk(rd, 32'h2);
        xfer(1'b0, SWDTC_OFF_TRIP, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h0101);
        xfer(1'b1, SWDTC_OFF_CTRL, 32'h2);
        xfer(1'b0, SWDTC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, SWDTC_OFF_LOAD, 32'd30);
        xfer(1'b1, SWDTC_OFF_CTRL, 32'h1);
        xfer(1'b1, SWDTC_OFF_RELOAD, 32'h1234);
        wait_low();
        i = 0;
        repeat (40) begin
            @(posedge pclk);
            #1;
            if (rst_n !== 1'b0) i++;
        end
        chk(32'(i), 32'h0);
        xfer(1'b0, SWDTC_OFF_TRIP, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h0201);
        xfer(1'b0, SWDTC_OFF_CTRL, 32'h0);
        chk(rd & 32'h6, 32'h6);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk({31'h0, rst_n}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, SWDTC_OFF_TRIP, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, SWDTC_OFF_LOAD, 32'd20);
        xfer(1'b1, SWDTC_OFF_CTRL, 32'h1);
        xfer(1'b1, SWDTC_OFF_CTRL, 32'h0);
        repeat (40) @(posedge pclk);
        #1;
        chk({31'h0, rst_n}, 32'h1);
        xfer(1'b0, SWDTC_OFF_COUNT, 32'h0);
        chk(rd, 32'd20);
        test_done();
    end
    initial begin
        #(50 * 20000);
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
